// ===== common/acs_pkg.sv
package acs_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned CHAN_W = 4;
  localparam int unsigned RAW_W  = 10;
  localparam int unsigned VAL_W  = 12;

  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] CONV_OUT_OFS = 8'h04;
  localparam logic [7:0] INJ_OUT_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS   = 8'h0C;

  localparam int CTRL_CHAN_LSB   = 0;
  localparam int CTRL_MODE_LSB   = 5;
  localparam int CTRL_START_BIT  = 7;
  localparam int CTRL_WAITRD_BIT = 9;
  localparam int CTRL_INJEN_BIT  = 10;
  localparam int CTRL_INJREQ_BIT = 11;
  localparam int CTRL_EIGHT_BIT  = 12;
  localparam int CTRL_OPMODE_BIT = 15;
  localparam int OUT_CHANNEL_NUMBER_FIELD_LSB    = 12;
  localparam int STAT_EOC_BIT    = 0;
  localparam int STAT_OVR_BIT    = 1;

  localparam logic [1:0]  MODE_FIX_SINGLE  = 2'h0;
  localparam logic [1:0]  MODE_FIX_CONT    = 2'h1;
  localparam logic [1:0]  MODE_SCAN_SINGLE = 2'h2;
  localparam logic [1:0]  MODE_SCAN_CONT   = 2'h3;
  localparam logic [3:0]  CHAN_RST         = 4'h0;
  localparam logic [1:0]  MODE_RST         = 2'h0;
  localparam logic [11:0] VAL_RST          = 12'h000;

  typedef enum logic [1:0] {ACS_IDLE, ACS_STD, ACS_INJ} acs_state_type;

endpackage : acs_pkg

// ===== hw/acs_conversion_sequencer.sv
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module acs_conversion_sequencer #(
  parameter int unsigned NUM_CHAN = 16
) (
  // Clock, reset, enable
  input  wire logic                      ref_clk,
  input  wire logic                      arst_n,
  input  wire logic                      ce,
  // Wishbone slave
  input  wire logic                      wbCycI,
  input  wire logic                      wbStbI,
  input  wire logic                      wbWeI,
  input  wire logic [acs_pkg::ADDR_W-1:0] wbAdrI,
  input  wire logic [3:0]                wbSelI,
  input  wire logic [acs_pkg::DATA_W-1:0] wbDatI,
  output logic      [acs_pkg::DATA_W-1:0] wbDatO,
  output logic                           wbAckO,
  // Analog core
  output logic                           coreStart,
  output logic                           coreAbort,
  output logic      [acs_pkg::CHAN_W-1:0] coreChannel,
  output logic                           coreEightBit,
  input  wire logic                      coreDone,
  input  wire logic [acs_pkg::RAW_W-1:0] coreData
);

  if (NUM_CHAN < 1 || NUM_CHAN > 16) begin : gChanCheck
    $error("NUM_CHAN must lie in 1..16");
  end

  localparam logic [3:0] MAX_CHAN = 4'(NUM_CHAN - 1);

  logic rstSync1Q, rstSync2Q, rstN;
  logic ackQ;
  logic [31:0] datOQ;
  logic [3:0] chanQ;
  logic [1:0] modeQ;
  logic startQ, waitRdQ, injEnQ, injReqQ, eightQ, opModeQ, activeQ;
  logic [3:0] convChanQ, injChanQ, bufChanQ, runChanQ;
  logic [11:0] convValQ, injValQ, bufValQ;
  logic eocQ, ovrQ, unreadQ, bufFullQ, stdGoQ, injPendQ;
  logic coreStartQ, coreAbortQ, coreEightQ;
  logic [3:0] coreChanQ;
  acs_pkg::acs_state_type stateQ;

  logic wbAcc, wrCtrl, wrInj, wrStat, convRead;
  logic [15:0] wMask, ctrlRd, ctrlWr, statRd;
  logic startEdge, injEdge, stdDone, injDone, holdNow, releaseNow, stepNow;
  logic stepCont, stepClrStart;
  logic [3:0] stepChan, topChan;
  logic [11:0] aligned;

  function automatic logic [11:0] alignRes(input logic enh, input logic eight,
                                           input logic [9:0] raw);
    logic [11:0] r;
    r = acs_pkg::VAL_RST;
    case ({enh, eight})
      2'b00:   r = {2'h0, raw};
      2'b01:   r = {2'h0, raw[7:0], 2'h0};
      2'b10:   r = {raw, 2'h0};
      default: r = {raw[7:0], 4'h0};
    endcase
    return r;
  endfunction : alignRes

  // Reset release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1Q <= 1'b0;
      rstSync2Q <= 1'b0;
    end else if (ce) begin
      rstSync1Q <= 1'b1;
      rstSync2Q <= rstSync1Q;
    end
  end
  assign rstN = rstSync2Q;

  // Bus decode
  always_comb begin
    wbAcc    = wbCycI & wbStbI & ~ackQ & ce;
    wrCtrl   = wbAcc & wbWeI & (wbAdrI == acs_pkg::CTRL_OFS);
    wrInj    = wbAcc & wbWeI & (wbAdrI == acs_pkg::INJ_OUT_OFS);
    wrStat   = wbAcc & wbWeI & (wbAdrI == acs_pkg::STATUS_OFS);
    convRead = wbAcc & ~wbWeI & (wbAdrI == acs_pkg::CONV_OUT_OFS);
    wMask    = {{8{wbSelI[1]}}, {8{wbSelI[0]}}};
    ctrlRd   = {opModeQ, 2'h0, eightQ, injReqQ, injEnQ, waitRdQ,
                activeQ | (stateQ != acs_pkg::ACS_IDLE), startQ, modeQ, 1'h0, chanQ};
    ctrlWr   = (ctrlRd & ~wMask) | (wbDatI[15:0] & wMask);
    statRd   = {14'h0000, ovrQ, eocQ};
    startEdge = wrCtrl & ctrlWr[acs_pkg::CTRL_START_BIT] & ~startQ;
    injEdge   = wrCtrl & ctrlWr[acs_pkg::CTRL_INJREQ_BIT] & ~injReqQ
                & ctrlWr[acs_pkg::CTRL_INJEN_BIT] & ctrlWr[acs_pkg::CTRL_WAITRD_BIT];
  end

  // Completion handling and next step
  always_comb begin
    stdDone    = (stateQ == acs_pkg::ACS_STD) & coreDone;
    injDone    = (stateQ == acs_pkg::ACS_INJ) & coreDone;
    aligned    = alignRes(opModeQ, coreEightQ, coreData);
    holdNow    = stdDone & waitRdQ & unreadQ & ~convRead;
    releaseNow = bufFullQ & convRead;
    stepNow    = (stdDone & ~holdNow) | releaseNow;
    topChan    = (chanQ > MAX_CHAN) ? MAX_CHAN : chanQ;
    stepCont     = 1'b0;
    stepClrStart = 1'b0;
    stepChan     = topChan;
    case (modeQ)
      acs_pkg::MODE_FIX_SINGLE: stepClrStart = 1'b1;
      acs_pkg::MODE_FIX_CONT:   stepCont = startQ;
      acs_pkg::MODE_SCAN_SINGLE: begin
        stepCont     = (runChanQ != 4'h0);
        stepChan     = runChanQ - 4'h1;
        stepClrStart = (runChanQ == 4'h0);
      end
      default: begin
        stepCont = (runChanQ != 4'h0) | startQ;
        stepChan = (runChanQ != 4'h0) ? runChanQ - 4'h1 : topChan;
      end
    endcase
  end

  // Wishbone answer, one cycle after the request
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ackQ  <= 1'b0;
      datOQ <= 32'h0000_0000;
    end else if (ce) begin
      ackQ <= wbAcc;
      if (wbAcc && !wbWeI) begin
        case (wbAdrI)
          acs_pkg::CTRL_OFS:     datOQ <= {16'h0000, ctrlRd};
          acs_pkg::CONV_OUT_OFS: datOQ <= {16'h0000, convChanQ, convValQ};
          acs_pkg::INJ_OUT_OFS:  datOQ <= {16'h0000, injChanQ, injValQ};
          acs_pkg::STATUS_OFS:   datOQ <= {16'h0000, statRd};
          default:               datOQ <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wbAckO = ackQ;
  assign wbDatO = datOQ;

  // Control fields
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      chanQ   <= acs_pkg::CHAN_RST;
      modeQ   <= acs_pkg::MODE_RST;
      startQ  <= 1'b0;
      waitRdQ <= 1'b0;
      injEnQ  <= 1'b0;
      injReqQ <= 1'b0;
      eightQ  <= 1'b0;
      opModeQ <= 1'b0;
    end else if (ce) begin
      if (wrCtrl) begin
        chanQ   <= ctrlWr[acs_pkg::CTRL_CHAN_LSB +: 4];
        modeQ   <= ctrlWr[acs_pkg::CTRL_MODE_LSB +: 2];
        waitRdQ <= ctrlWr[acs_pkg::CTRL_WAITRD_BIT];
        injEnQ  <= ctrlWr[acs_pkg::CTRL_INJEN_BIT];
        eightQ  <= ctrlWr[acs_pkg::CTRL_EIGHT_BIT];
        opModeQ <= ctrlWr[acs_pkg::CTRL_OPMODE_BIT];
        startQ  <= ctrlWr[acs_pkg::CTRL_START_BIT];
        injReqQ <= ctrlWr[acs_pkg::CTRL_INJREQ_BIT];
      end
      if (stepNow && !stepCont && stepClrStart && !startEdge) begin
        startQ <= 1'b0;
      end
      if (stateQ == acs_pkg::ACS_IDLE && injPendQ && !startEdge && !injEdge) begin
        injReqQ <= 1'b0;
      end
    end
  end

  // Sequencer and core drive
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      stateQ     <= acs_pkg::ACS_IDLE;
      activeQ    <= 1'b0;
      stdGoQ     <= 1'b0;
      injPendQ   <= 1'b0;
      runChanQ   <= acs_pkg::CHAN_RST;
      coreStartQ <= 1'b0;
      coreAbortQ <= 1'b0;
      coreChanQ  <= acs_pkg::CHAN_RST;
      coreEightQ <= 1'b0;
    end else if (ce) begin
      coreStartQ <= 1'b0;
      coreAbortQ <= 1'b0;
      if (stateQ != acs_pkg::ACS_IDLE && coreDone) begin
        stateQ <= acs_pkg::ACS_IDLE;
      end
      if (startEdge) begin
        activeQ  <= 1'b1;
        stdGoQ   <= 1'b1;
        runChanQ <= (ctrlWr[3:0] > MAX_CHAN) ? MAX_CHAN : ctrlWr[3:0];
        if (stateQ == acs_pkg::ACS_STD && !coreDone) begin
          coreAbortQ <= 1'b1;
          stateQ     <= acs_pkg::ACS_IDLE;
        end
      end else if (stepNow) begin
        stdGoQ <= stepCont;
        if (stepCont) begin
          runChanQ <= stepChan;
        end else begin
          activeQ <= 1'b0;
        end
      end else if (stateQ == acs_pkg::ACS_IDLE) begin
        if (injPendQ) begin
          injPendQ   <= 1'b0;
          coreStartQ <= 1'b1;
          coreChanQ  <= injChanQ;
          coreEightQ <= eightQ;
          stateQ     <= acs_pkg::ACS_INJ;
        end else if (stdGoQ && !bufFullQ) begin
          stdGoQ     <= 1'b0;
          coreStartQ <= 1'b1;
          coreChanQ  <= runChanQ;
          coreEightQ <= eightQ;
          stateQ     <= acs_pkg::ACS_STD;
        end
      end
      if (injEdge) begin
        injPendQ <= 1'b1;
      end
    end
  end
  assign coreStart    = coreStartQ;
  assign coreAbort    = coreAbortQ;
  assign coreChannel  = coreChanQ;
  assign coreEightBit = coreEightQ;

  // Result registers and flags
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      convChanQ <= acs_pkg::CHAN_RST;
      convValQ  <= acs_pkg::VAL_RST;
      injChanQ  <= acs_pkg::CHAN_RST;
      injValQ   <= acs_pkg::VAL_RST;
      bufChanQ  <= acs_pkg::CHAN_RST;
      bufValQ   <= acs_pkg::VAL_RST;
      bufFullQ  <= 1'b0;
      unreadQ   <= 1'b0;
      eocQ      <= 1'b0;
      ovrQ      <= 1'b0;
    end else if (ce) begin
      if (convRead) begin
        unreadQ <= 1'b0;
      end
      if (wrStat && wbSelI[0]) begin
        eocQ <= eocQ & ~wbDatI[acs_pkg::STAT_EOC_BIT];
        ovrQ <= ovrQ & ~wbDatI[acs_pkg::STAT_OVR_BIT];
      end
      if (wrInj && wbSelI[1]) begin
        injChanQ <= wbDatI[acs_pkg::OUT_CHANNEL_NUMBER_FIELD_LSB +: 4];
      end
      if (holdNow) begin
        bufValQ  <= aligned;
        bufChanQ <= coreChanQ;
        bufFullQ <= 1'b1;
      end else if (stdDone) begin
        convValQ  <= aligned;
        convChanQ <= coreChanQ;
        unreadQ   <= 1'b1;
        eocQ      <= 1'b1;
        if (unreadQ && !convRead) begin
          ovrQ <= 1'b1;
        end
      end else if (releaseNow) begin
        convValQ  <= bufValQ;
        convChanQ <= bufChanQ;
        bufFullQ  <= 1'b0;
        unreadQ   <= 1'b1;
        eocQ      <= 1'b1;
      end
      if (injDone) begin
        injValQ <= aligned;
        ovrQ    <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  AST_ALIGN_COMPAT: assert property (ce && stdDone && !holdNow && !opModeQ
    |=> convValQ[11:10] == 2'h0)
    else $error("compatibility result leaks into top bits");
  AST_ALIGN_ENH8: assert property (ce && stdDone && !holdNow && opModeQ && coreEightQ
    |=> convValQ[3:0] == 4'h0 && convValQ[11:4] == $past(coreData[7:0]))
    else $error("enhanced 8-bit result misplaced");
  AST_SINGLE_STOP: assert property (ce && stdDone && !holdNow && !startEdge
    && modeQ == acs_pkg::MODE_FIX_SINGLE |=> !activeQ && !startQ)
    else $error("fixed single did not stop");
  AST_SCAN_DOWN: assert property (ce && stdDone && !holdNow && !startEdge && modeQ[1]
    && runChanQ != 4'h0 |=> stdGoQ && runChanQ == $past(runChanQ) - 4'h1 && eocQ)
    else $error("scan did not step down");
  AST_OVERRUN: assert property (ce && stdDone && !waitRdQ && unreadQ && !convRead
    |=> ovrQ && unreadQ)
    else $error("overrun not flagged");
  AST_HOLD: assert property (ce && holdNow && !startEdge
    |=> bufFullQ && activeQ && !$rose(eocQ) && !stdGoQ
    && (startQ == $past(startQ) || $past(wrCtrl)))
    else $error("wait-for-read did not park result");
  AST_RELEASE: assert property (ce && releaseNow
    |=> !bufFullQ && eocQ && convValQ == $past(bufValQ))
    else $error("parked result not released");
  AST_INJ_DONE: assert property (ce && injDone
    |=> ovrQ && injValQ == $past(aligned) && stateQ == acs_pkg::ACS_IDLE)
    else $error("injection result not stored");
  AST_ABORT: assert property (ce && startEdge && stateQ == acs_pkg::ACS_STD && !coreDone
    |=> coreAbortQ && stateQ == acs_pkg::ACS_IDLE ##1 (coreStartQ || !$past(ce)))
    else $error("restart did not abort and relaunch");
  AST_CHANNEL_NUMBER_FIELD: assert property (ce && stdDone && !holdNow
    |=> convChanQ == $past(coreChanQ))
    else $error("channel number not loaded");
  AST_SCAN_STOP: assert property (ce && stepNow && !startEdge
    && modeQ == acs_pkg::MODE_SCAN_SINGLE && runChanQ == 4'h0 |=> !activeQ && !startQ)
    else $error("scan single did not stop after the last channel");
  AST_FIX_STOP: assert property (ce && stepNow && !startEdge
    && modeQ == acs_pkg::MODE_FIX_CONT && !startQ |=> !activeQ && !stdGoQ)
    else $error("fixed continuous did not stop after start cleared");
  AST_INJ_FIRST: assert property (ce && stateQ == acs_pkg::ACS_IDLE && injPendQ
    && !startEdge && !stepNow
    |=> coreStartQ && coreChanQ == $past(injChanQ) && stateQ == acs_pkg::ACS_INJ)
    else $error("pending injection not dispatched first");
  AST_SUSPEND: assert property (ce && bufFullQ && stateQ == acs_pkg::ACS_IDLE && !injPendQ
    |=> !coreStartQ)
    else $error("standard conversion launched while result parked");

  COV_SCAN_WRAP: cover property (ce && stepNow && modeQ == acs_pkg::MODE_SCAN_CONT
    && runChanQ == 4'h0);
  COV_HOLD_RELEASE: cover property (bufFullQ ##[1:50] releaseNow);
  COV_INJECT: cover property (injDone);
  COV_RESTART: cover property (coreAbortQ);

endmodule : acs_conversion_sequencer
`default_nettype wire

// ===== verif/test_acs_conversion_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module test_acs_conversion_sequencer;
  logic        ref_clk, arst_n, ce, wbCycI, wbStbI, wbWeI;
  logic        wbAckO, coreStart, coreAbort, coreEightBit, coreDone;
  logic [7:0]  wbAdrI;
  logic [3:0]  wbSelI, coreChannel;
  logic [31:0] wbDatI, wbDatO, rd;
  logic [9:0]  coreData;
  int          err_total, cmp_count, startCnt, abortCnt, nxt, i;
  localparam logic [7:0]  CT  = acs_pkg::CTRL_OFS;
  localparam logic [7:0]  CO  = acs_pkg::CONV_OUT_OFS;
  localparam logic [7:0]  IO  = acs_pkg::INJ_OUT_OFS;
  localparam logic [7:0]  ST  = acs_pkg::STATUS_OFS;
  localparam logic [31:0] BSY = 32'h180;

  acs_conversion_sequencer dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .wbCycI(wbCycI), .wbStbI(wbStbI),
    .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbAckO(wbAckO), .coreStart(coreStart), .coreAbort(coreAbort),
    .coreChannel(coreChannel), .coreEightBit(coreEightBit), .coreDone(coreDone),
    .coreData(coreData));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Pulses stand a full cycle, so mid-cycle sampling counts each once
  always @(negedge ref_clk) begin
    if (coreStart === 1'b1) startCnt++;
    if (coreAbort === 1'b1) abortCnt++;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    wbWeI  <= we;
    wbAdrI <= a;
    wbSelI <= 4'h3;
    wbDatI <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAckO !== 1'b1 && n < 50);
    chk("wbAck", 1'b1, wbAckO);
    rd = wbDatO;
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
    wbWeI  <= 1'b0;
    @(posedge ref_clk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rc(input string s, input logic [7:0] a, input logic [31:0] m, e);
    wb(1'b0, a, 32'h0);
    chk(s, e & m, rd & m);
  endtask : rc

  task automatic waitN(input logic [3:0] ch);
    int n;
    n = 0;
    nxt++;
    while (startCnt < nxt && n < 80) begin
      @(posedge ref_clk);
      n++;
    end
    chk("startCount", nxt, startCnt);
    chk("coreChannel", ch, coreChannel);
  endtask : waitN

  task automatic conv(input logic [9:0] d);
    @(posedge ref_clk);
    coreDone <= 1'b1;
    coreData <= d;
    @(posedge ref_clk);
    coreDone <= 1'b0;
    coreData <= ~d;
  endtask : conv

  task automatic idle();
    repeat (6) @(posedge ref_clk);
    chk("startCount", nxt, startCnt);
    rc("ctrlBusy", CT, BSY, 32'h0);
  endtask : idle

  // Flags f: {enhanced, eightBit, injRequest, injEnable, waitRead, start}
  function automatic logic [31:0] ctl(input logic [3:0] c, input logic [1:0] m,
                                      input logic [5:0] f);
    ctl = 32'h0;
    ctl[acs_pkg::CTRL_CHAN_LSB +: 4] = c;
    ctl[acs_pkg::CTRL_MODE_LSB +: 2] = m;
    ctl[acs_pkg::CTRL_START_BIT]  = f[0];
    ctl[acs_pkg::CTRL_WAITRD_BIT] = f[1];
    ctl[acs_pkg::CTRL_INJEN_BIT]  = f[2];
    ctl[acs_pkg::CTRL_INJREQ_BIT] = f[3];
    ctl[acs_pkg::CTRL_EIGHT_BIT]  = f[4];
    ctl[acs_pkg::CTRL_OPMODE_BIT] = f[5];
  endfunction : ctl

  function automatic logic [31:0] ex(input logic [3:0] c, input logic [9:0] r,
                                     input logic e, input logic op);
    logic [11:0] v;
    case ({op, e})
      2'h0: v = {2'h0, r};
      2'h1: v = {2'h0, r[7:0], 2'h0};
      2'h2: v = {r, 2'h0};
      default: v = {r[7:0], 4'h0};
    endcase
    ex = {16'h0, c, v};
  endfunction : ex

  // Whole run needs a few hundred cycles
  initial begin
    #100us;
    err_total++;
    report_and_stop();
  end

  initial begin
    ce = 1'b1;
    arst_n = 1'b0;
    wbCycI = 1'b0;
    wbStbI = 1'b0;
    wbWeI = 1'b0;
    wbAdrI = 8'h00;
    wbSelI = 4'h0;
    wbDatI = 32'h0;
    coreDone = 1'b0;
    coreData = 10'h000;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rc("unmapped", 8'h10, 32'hFFFFFFFF, 32'h0);
    rc("convOut", CO, 32'hFFFF, 32'h0);
    rc("status", ST, 32'h3, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(CT, ctl(4'h5 + i[3:0], acs_pkg::MODE_FIX_SINGLE, {i[1:0], 4'h1}));
      waitN(4'h5 + i[3:0]);
      chk("coreEightBit", i[0], coreEightBit);
      conv(10'h3D6);
      rc("convOut", CO, 32'hFFFF, ex(4'h5 + i[3:0], 10'h3D6, i[0], i[1]));
      rc("status", ST, 32'h1, 32'h1);
      idle();
      wr(ST, 32'h3);
    end
    wr(CT, ctl(4'h3, acs_pkg::MODE_SCAN_SINGLE, 6'h01));
    for (i = 3; i >= 0; i--) begin
      waitN(i[3:0]);
      if (i == 2) wr(CT, ctl(4'h7, acs_pkg::MODE_SCAN_SINGLE, 6'h01));
      conv(10'h100 + i[9:0]);
      rc("convOut", CO, 32'hFFFF, ex(i[3:0], 10'h100 + i[9:0], 1'b0, 1'b0));
    end
    idle();
    wr(CT, ctl(4'h2, acs_pkg::MODE_FIX_CONT, 6'h01));
    waitN(4'h2);
    conv(10'h0AA);
    waitN(4'h2);
    conv(10'h155);
    waitN(4'h2);
    rc("overrun", ST, 32'h2, 32'h2);
    rc("convOut", CO, 32'hFFFF, ex(4'h2, 10'h155, 1'b0, 1'b0));
    wr(CT, ctl(4'h2, acs_pkg::MODE_FIX_SINGLE, 6'h01));
    conv(10'h011);
    idle();
    rc("convOut", CO, 32'hFFFF, ex(4'h2, 10'h011, 1'b0, 1'b0));
    wr(ST, 32'h3);
    wr(CT, ctl(4'h4, acs_pkg::MODE_FIX_CONT, 6'h03));
    waitN(4'h4);
    conv(10'h2C3);
    waitN(4'h4);
    wr(ST, 32'h3);
    conv(10'h13C);
    repeat (8) @(posedge ref_clk);
    chk("startCount", nxt, startCnt);
    rc("status", ST, 32'h3, 32'h0);
    rc("ctrlBusy", CT, BSY, BSY);
    rc("convOut", CO, 32'hFFFF, ex(4'h4, 10'h2C3, 1'b0, 1'b0));
    waitN(4'h4);
    rc("status", ST, 32'h3, 32'h1);
    rc("convOut", CO, 32'hFFFF, ex(4'h4, 10'h13C, 1'b0, 1'b0));
    wr(CT, ctl(4'h4, acs_pkg::MODE_FIX_CONT, 6'h02));
    rc("ctrlBusy", CT, BSY, 32'h100);
    conv(10'h001);
    idle();
    rc("convOut", CO, 32'hFFFF, ex(4'h4, 10'h001, 1'b0, 1'b0));
    wr(ST, 32'h3);
    wr(IO, 32'h9000);
    rc("injChan", IO, 32'hF000, 32'h9000);
    wr(CT, ctl(4'h6, acs_pkg::MODE_FIX_CONT, 6'h07));
    waitN(4'h6);
    wr(CT, ctl(4'h6, acs_pkg::MODE_FIX_CONT, 6'h0F));
    chk("startCount", nxt, startCnt);
    conv(10'h2F0);
    waitN(4'h9);
    conv(10'h1E7);
    rc("injOut", IO, 32'hFFFF, ex(4'h9, 10'h1E7, 1'b0, 1'b0));
    rc("overrun", ST, 32'h2, 32'h2);
    waitN(4'h6);
    rc("convOut", CO, 32'hFFFF, ex(4'h6, 10'h2F0, 1'b0, 1'b0));
    wr(CT, ctl(4'h6, acs_pkg::MODE_FIX_CONT, 6'h07));
    repeat (4) @(posedge ref_clk);
    chk("abortCount", 0, abortCnt);
    chk("startCount", nxt, startCnt);
    wr(CT, ctl(4'h6, acs_pkg::MODE_FIX_CONT, 6'h06));
    wr(CT, ctl(4'h8, acs_pkg::MODE_FIX_CONT, 6'h07));
    waitN(4'h8);
    chk("abortCount", 1, abortCnt);
    wr(CT, ctl(4'h8, acs_pkg::MODE_FIX_CONT, 6'h06));
    conv(10'h0F0);
    idle();
    wr(CT, ctl(4'h1, acs_pkg::MODE_SCAN_CONT, 6'h01));
    for (i = 0; i < 4; i++) begin
      waitN({3'h0, ~i[0]});
      if (i == 2) wr(CT, ctl(4'h1, acs_pkg::MODE_SCAN_CONT, 6'h00));
      conv(10'h050);
    end
    idle();
    // Completion while enable is low must be ignored
    wr(CT, ctl(4'h3, acs_pkg::MODE_FIX_SINGLE, 6'h01));
    waitN(4'h3);
    ce <= 1'b0;
    conv(10'h222);
    ce <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rc("ctrlBusy", CT, BSY, BSY);
    conv(10'h222);
    idle();
    rc("convOut", CO, 32'hFFFF, ex(4'h3, 10'h222, 1'b0, 1'b0));
    report_and_stop();
  end
endmodule : test_acs_conversion_sequencer
`default_nettype wire
